// *** rtl/rcs_supervisor.sv ***
// Operation
// RULE1: Watchdog reset begins at counter value 7ffc
// RULE2: Watchdog reset lasts 8 or 128 machine cycles
// RULE3: Watchdog reset keeps timer running, sets flag
// RULE4: Watchdog flag holds until external reset/software
// RULE5: Main slower than RC divided by ten fails
// RULE6: On failure select RC clock and reset
// RULE7: Oscillator reset keeps wdog flag, stops timer
// RULE8: Recovery holds reset on RC for 1 ms
// RULE9: External reset still active keeps device reset
// RULE10: Software sets/clears osc flag; external reset clears
// RULE11: Power-on reset runs from RC clock quickly
// RULE12: Oscillator monitor always on, no disable bit; code freezes it while in power-down
// RULE13: Power-down stops both oscillators, restart with delay
// RULE14: Pin/USB wake resumes with wake interrupt
// RULE15: Power-down wins over simultaneous idle request
// RULE16: Power-down needs enable then separate start
// RULE17: Idle needs enable then separate start
// RULE18: Two free general purpose flag bits
// RULE19: External wake needs wake enable bit set
// RULE20: Wake source: 0 interrupt pin, 1 USB
// RULE21: Extended register reachable only with map select
// RULE22: Same-write enable and start ignored, self-clear
// RULE23: Edge counting compare over common RC window
`timescale 1ns/1ns
`default_nettype none

module rcs_supervisor #(
  parameter int STAB_CYC  = rcs_pkg::STAB_CYC_DEF,
  parameter int WIN_EDGES = rcs_pkg::WIN_EDGES_DEF
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire rcs_pkg::rcs_wb_req_s wb_req_i,
  output rcs_pkg::rcs_wb_rsp_s     wb_rsp_o,
  input  wire rcs_pkg::rcs_pins_s  pins_i,
  input  wire logic [14:0]         wdt_count_i,
  input  wire logic                wdt_run_i,
  input  wire logic                wdt_psel_i,
  input  wire logic                mcyc_i,
  input  wire logic                irq_i,
  output logic                     sys_reset_o,
  output logic                     clk_sel_rc_o,
  output logic                     wdt_stop_o,
  output logic                     idle_o,
  output logic                     powerdown_o,
  output logic                     core_hold_o,
  output logic                     wake_irq_o
);
  import rcs_pkg::*;

  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  if (WIN_EDGES < 1 || RC_DIV * WIN_EDGES > 255) begin : g_bad_win
    $error("WIN_EDGES out of range");
  end
  if (STAB_CYC < 1 || STAB_CYC > 65535) begin : g_bad_stab
    $error("STAB_CYC out of range");
  end

  localparam logic [7:0]  WIN_LAST  = 8'(RC_DIV * WIN_EDGES - 1);
  localparam logic [7:0]  WIN_NEED  = 8'(WIN_EDGES);
  localparam logic [15:0] STAB_LAST = 16'(STAB_CYC - 1);

  function automatic logic rise(input logic cur, input logic prev);
    rise = cur & ~prev;
  endfunction : rise

  rcs_state_s r;
  rcs_state_s n;

  logic       acc;
  logic       wr;
  logic [7:0] idx;
  logic [7:0] d;
  logic       ext_rst;
  logic       main_edge;
  logic       rc_edge;
  logic       win_done;
  logic       win_pass;
  logic       wdt_trip;
  logic       osc_rst_now;
  logic       pd_go;
  logic       idle_go;
  logic       wake_src;
  logic [7:0] wdt_len;
  logic       any_rst;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    n           = r;
    idx         = wb_req_i.adr[ADR_W-1:2];
    d           = wb_req_i.dat[7:0];
    acc         = wb_req_i.cyc & wb_req_i.stb & ~r.ack;
    wr          = acc & wb_req_i.we & wb_req_i.sel[0];
    ext_rst     = ~r.s2.ext_rst_n;
    main_edge   = rise(r.s2.osc_main, r.prev_main);
    rc_edge     = rise(r.s2.osc_rc, r.prev_rc);
    win_done    = 1'b0;
    win_pass    = 1'b0;
    pd_go       = 1'b0;
    idle_go     = 1'b0;
    wdt_len     = wdt_psel_i ? WDT_LEN_LONG : WDT_LEN_SHORT;
    wake_src    = r.wake_sel ? r.s2.usb_act : ~r.s2.wake_pin_n; // RULE20

    // Pin synchronisers
    n.s1        = pins_i;
    n.s2        = r.s1;
    n.prev_main = r.s2.osc_main;
    n.prev_rc   = r.s2.osc_rc;

    // ****************************************************************
    // Register bus
    // ****************************************************************
    n.ack  = acc;
    n.rdat = 32'h0000_0000;
    if (acc && !wb_req_i.we)
    begin
      case (idx)
        IDX_PCTL:
        begin
          n.rdat[PC_FLAG0] = r.gen_flag0;                        // RULE18
          n.rdat[PC_FLAG1] = r.gen_flag1;
        end
        IDX_PCTLX:
        begin
          if (r.map_sel)                                         // RULE21
          begin
            n.rdat[PX_WAKE_EN]  = r.wake_en;
            n.rdat[PX_WAKE_SEL] = r.wake_sel;
          end
        end
        IDX_SYSCTL: n.rdat[SC_MAP_SEL] = r.map_sel;
        IDX_WDSTAT:
        begin
          n.rdat[ST_WDOG] = r.wdog_flag;
          n.rdat[ST_OSCF] = r.oscf_flag;
        end
        default: n.rdat = 32'h0000_0000;
      endcase
    end

    if (wr)
    begin
      case (idx)
        IDX_PCTL:
        begin
          // Start only after an earlier separate enable write
          pd_go       = d[PC_PD_GO] & r.pd_arm & ~d[PC_PD_EN];      // RULE16
          idle_go     = d[PC_IDLE_GO] & r.idle_arm & ~d[PC_IDLE_EN]; // RULE17
          n.pd_arm    = d[PC_PD_EN] & ~d[PC_PD_GO];                 // RULE22
          n.idle_arm  = d[PC_IDLE_EN] & ~d[PC_IDLE_GO];             // RULE22
          n.gen_flag0 = d[PC_FLAG0];                                // RULE18
          n.gen_flag1 = d[PC_FLAG1];                                // RULE18
        end
        IDX_PCTLX:
        begin
          if (r.map_sel)                                            // RULE21
          begin
            n.wake_en  = d[PX_WAKE_EN];                             // RULE19
            n.wake_sel = d[PX_WAKE_SEL];                            // RULE20
          end
        end
        IDX_SYSCTL: n.map_sel = d[SC_MAP_SEL];
        IDX_WDSTAT:
        begin
          n.wdog_flag = d[ST_WDOG];                                 // RULE4
          n.oscf_flag = d[ST_OSCF];                                 // RULE10
        end
        default: n.map_sel = r.map_sel;
      endcase
    end

    // ****************************************************************
    // Power modes
    // ****************************************************************
    case (r.pm_st)
      PM_RUN:
      begin
        if (pd_go)
          n.pm_st = PM_PD;                                       // RULE15
        else if (idle_go)
          n.pm_st = PM_IDLE;
      end
      PM_IDLE:
      begin
        if (irq_i)
          n.pm_st = PM_RUN;
      end
      PM_PD:
      begin
        if (r.wake_en && wake_src)                               // RULE19
        begin
          n.pm_st    = PM_RUN;
          n.osc_st   = OSC_FAIL;                                 // RULE13
          n.waking   = 1'b1;
          n.rc_cnt   = 8'h00;
          n.main_cnt = 8'h00;
        end
      end
      default: n.pm_st = PM_RUN;
    endcase

    // ****************************************************************
    // Oscillator monitor, frozen only while oscillators are stopped
    // ****************************************************************
    if (r.pm_st != PM_PD)                                        // RULE12
    begin
      if (rc_edge)                                               // RULE23
      begin
        if (r.rc_cnt == WIN_LAST)
        begin
          win_done   = 1'b1;
          win_pass   = (r.main_cnt >= WIN_NEED);                 // RULE5
          n.rc_cnt   = 8'h00;
          n.main_cnt = 8'h00;
        end
        else
          n.rc_cnt = r.rc_cnt + 8'h01;
      end
      if (main_edge && !win_done && r.main_cnt != 8'hff)         // RULE23
        n.main_cnt = r.main_cnt + 8'h01;

      case (r.osc_st)
        OSC_FAIL:
        begin
          if (win_done && win_pass)
          begin
            n.osc_st   = OSC_STAB;
            n.stab_cnt = 16'h0000;
          end
        end
        OSC_STAB:
        begin
          if (win_done && !win_pass)
            n.osc_st = OSC_FAIL;
          else if (r.stab_cnt == STAB_LAST)
            n.osc_st = OSC_OK;                                   // RULE8
          else
            n.stab_cnt = r.stab_cnt + 16'h0001;
        end
        OSC_OK:
        begin
          if (win_done && !win_pass)
            n.osc_st = OSC_FAIL;                                 // RULE6
        end
        default: n.osc_st = OSC_FAIL;
      endcase
    end
    else
    begin
      n.rc_cnt   = 8'h00;
      n.main_cnt = 8'h00;
    end

    // Wake-up finishes once the main oscillator is trusted
    n.o_wake_irq = 1'b0;
    if (r.waking && n.osc_st == OSC_OK)
    begin
      n.waking     = 1'b0;
      n.o_wake_irq = 1'b1;                                       // RULE14
    end

    // ****************************************************************
    // Watchdog reset pulse
    // ****************************************************************
    wdt_trip = wdt_run_i && wdt_count_i == WDT_TRIP && !r.wdt_rst
               && r.pm_st == PM_RUN;                             // RULE1
    if (wdt_trip)
    begin
      n.wdt_rst = 1'b1;
      n.wdt_cnt = 8'h00;
    end
    else if (r.wdt_rst && mcyc_i)
    begin
      if (r.wdt_cnt == wdt_len - 8'h01)
        n.wdt_rst = 1'b0;                                        // RULE2
      else
        n.wdt_cnt = r.wdt_cnt + 8'h01;
    end

    // ****************************************************************
    // Reset sources and status flags
    // ****************************************************************
    if (ext_rst)
    begin
      n.wdog_flag = 1'b0;                                        // RULE10
      n.oscf_flag = 1'b0;                                        // RULE10
      n.waking    = 1'b0;
      n.wdt_rst   = 1'b0;
      if (r.pm_st == PM_PD)
        n.osc_st = OSC_FAIL;
    end
    osc_rst_now = (n.osc_st != OSC_OK) && !n.waking;             // RULE6
    if (wdt_trip)
      n.wdog_flag = 1'b1;                                        // RULE3
    if (osc_rst_now)
      n.oscf_flag = 1'b1;                                        // RULE7

    any_rst = ext_rst || osc_rst_now || n.wdt_rst;               // RULE9
    if (any_rst)
    begin
      n.pm_st    = PM_RUN;
      n.idle_arm = 1'b0;
      n.pd_arm   = 1'b0;
      n.gen_flag0 = 1'b0;
      n.gen_flag1 = 1'b0;
      n.wake_en   = 1'b0;
      n.wake_sel  = 1'b0;
      n.map_sel   = 1'b0;
    end

    // ****************************************************************
    // Registered outputs
    // ****************************************************************
    n.o_sys_reset = any_rst;                                     // RULE9
    n.o_clk_rc    = n.osc_st != OSC_OK;                          // RULE6
    n.o_wdt_stop  = ext_rst || osc_rst_now || n.pm_st != PM_RUN; // RULE7
    n.o_idle      = n.pm_st == PM_IDLE;
    n.o_pd        = n.pm_st == PM_PD;                            // RULE13
    n.o_hold      = n.waking;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r             <= '0;
      // Pin stages start idle: no false reset or wake after reset
      r.s1.ext_rst_n  <= 1'b1;
      r.s1.wake_pin_n <= 1'b1;
      r.s2.ext_rst_n  <= 1'b1;
      r.s2.wake_pin_n <= 1'b1;
      r.o_sys_reset <= 1'b1;                                     // RULE11
      r.o_clk_rc    <= 1'b1;                                     // RULE11
      r.o_wdt_stop  <= 1'b1;
    end
    else
      r <= n;
  end

  assign wb_rsp_o.ack = r.ack;
  assign wb_rsp_o.dat = r.rdat;
  assign sys_reset_o  = r.o_sys_reset;
  assign clk_sel_rc_o = r.o_clk_rc;
  assign wdt_stop_o   = r.o_wdt_stop;
  assign idle_o       = r.o_idle;
  assign powerdown_o  = r.o_pd;
  assign core_hold_o  = r.o_hold;
  assign wake_irq_o   = r.o_wake_irq;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_wdt_trip_start: assert property (wdt_trip |=> sys_reset_o && r.wdt_rst) // RULE1
    else $error("watchdog trip did not start reset");
  a_wdt_pulse_len: assert property ($fell(r.wdt_rst) && !$past(ext_rst) |->
      $past(mcyc_i) && $past(r.wdt_cnt) == $past(wdt_len) - 8'h01) // RULE2
    else $error("watchdog reset length wrong");
  a_wdt_flag_set: assert property (wdt_trip |=> r.wdog_flag) // RULE3
    else $error("watchdog flag not set");
  a_wdt_flag_hold: assert property (r.wdog_flag && !ext_rst &&
      !(wr && idx == IDX_WDSTAT) |=> r.wdog_flag) // RULE4
    else $error("watchdog flag lost");
  a_osc_fail_reset: assert property (clk_sel_rc_o && !core_hold_o |-> sys_reset_o) // RULE6
    else $error("RC clock without reset");
  a_osc_fail_flag: assert property (r.osc_st == OSC_OK && win_done && !win_pass
      && r.pm_st != PM_PD |=> r.oscf_flag && clk_sel_rc_o && wdt_stop_o) // RULE7
    else $error("oscillator failure not flagged");
  a_stab_before_ok: assert property ($fell(clk_sel_rc_o) |->
      $past(r.osc_st) == OSC_STAB && $past(r.stab_cnt) == STAB_LAST) // RULE8
    else $error("clock switched back early");
  a_ext_holds_rst: assert property (ext_rst |=> sys_reset_o) // RULE9
    else $error("external reset not honoured");
  a_ext_clr_flags: assert property (ext_rst && !osc_rst_now |=> !r.oscf_flag) // RULE10
    else $error("external reset did not clear flag");
  a_same_write_idle: assert property (wr && idx == IDX_PCTL && d[PC_IDLE_EN]
      && d[PC_IDLE_GO] && !d[PC_PD_GO] |=> !idle_o && !r.idle_arm) // RULE22
    else $error("idle entered on single write");
  a_pd_precedence: assert property (pd_go && idle_go && !any_rst |=> powerdown_o && !idle_o) // RULE15
    else $error("idle taken over power-down");

endmodule : rcs_supervisor

`default_nettype wire

// *** rtl/rcs_pkg.sv ***
package rcs_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ      = 10;
  localparam int STAB_TIME_US = 1000;
  localparam int STAB_CYC_DEF = STAB_TIME_US * CLK_MHZ;
  localparam int RC_DIV       = 10;
  localparam int WIN_EDGES_DEF = 4;

  // ****************************************************************
  // Register indices (byte address = index * 4)
  // ****************************************************************
  localparam logic [7:0] IDX_PCTL   = 8'h87;
  localparam logic [7:0] IDX_PCTLX  = 8'h88;
  localparam logic [7:0] IDX_SYSCTL = 8'hb1;
  localparam logic [7:0] IDX_WDSTAT = 8'hc0;
  localparam int         ADR_W      = 10;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int PC_IDLE_EN = 0;
  localparam int PC_PD_EN   = 1;
  localparam int PC_FLAG0    = 2;
  localparam int PC_FLAG1    = 3;
  localparam int PC_IDLE_GO  = 5;
  localparam int PC_PD_GO    = 6;
  localparam int PX_WAKE_SEL = 4;
  localparam int PX_WAKE_EN  = 7;
  localparam int SC_MAP_SEL  = 4;
  localparam int ST_WDOG     = 2;
  localparam int ST_OSCF     = 3;

  // ****************************************************************
  // Watchdog reset
  // ****************************************************************
  localparam logic [14:0] WDT_TRIP      = 15'h7ffc;
  localparam logic [7:0]  WDT_LEN_SHORT = 8'h08;
  localparam logic [7:0]  WDT_LEN_LONG  = 8'h80;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {OSC_FAIL, OSC_STAB, OSC_OK} rcs_osc_e;
  typedef enum logic [1:0] {PM_RUN, PM_IDLE, PM_PD} rcs_pm_e;

  typedef struct packed {
    logic              cyc;
    logic              stb;
    logic              we;
    logic [ADR_W-1:0]  adr;
    logic [3:0]        sel;
    logic [31:0]       dat;
  } rcs_wb_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } rcs_wb_rsp_s;

  typedef struct packed {
    logic ext_rst_n;
    logic wake_pin_n;
    logic usb_act;
    logic osc_main;
    logic osc_rc;
  } rcs_pins_s;

  typedef struct packed {
    rcs_pins_s   s1;
    rcs_pins_s   s2;
    logic        prev_main;
    logic        prev_rc;
    logic [7:0]  rc_cnt;
    logic [7:0]  main_cnt;
    logic [15:0] stab_cnt;
    rcs_osc_e    osc_st;
    rcs_pm_e     pm_st;
    logic        waking;
    logic        wdt_rst;
    logic [7:0]  wdt_cnt;
    logic        idle_arm;
    logic        pd_arm;
    logic        gen_flag0;
    logic        gen_flag1;
    logic        wake_en;
    logic        wake_sel;
    logic        map_sel;
    logic        wdog_flag;
    logic        oscf_flag;
    logic        ack;
    logic [31:0] rdat;
    logic        o_sys_reset;
    logic        o_clk_rc;
    logic        o_wdt_stop;
    logic        o_idle;
    logic        o_pd;
    logic        o_hold;
    logic        o_wake_irq;
  } rcs_state_s;

endpackage : rcs_pkg

// *** verif/rcs_far_model.sv ***
`timescale 1ns/1ns
`default_nettype none

module rcs_far_model (
  input  wire logic clk_i,
  input  wire logic main_en_i,
  input  wire logic pd_i,
  output logic      osc_main_o,
  output logic      osc_rc_o,
  output logic      mcyc_o
);
  // ****************************************************************
  // Oscillator sources: RC at 1 MHz, main at 2.5 MHz
  // ****************************************************************
  logic [3:0] cnt;

  initial
  begin
    cnt = 4'h0;
    osc_main_o = 1'b0;
    osc_rc_o = 1'b0;
    mcyc_o = 1'b0;
  end

  always @(posedge clk_i)
  begin
    cnt <= (cnt == 4'h9) ? 4'h0 : cnt + 4'h1;
    mcyc_o <= cnt[0];
    // Both sources freeze in power-down
    if (!pd_i)
    begin
      if (cnt == 4'h4 || cnt == 4'h9)
        osc_rc_o <= ~osc_rc_o;
      // Main stops dead when failed
      if (main_en_i && cnt[0])
        osc_main_o <= ~osc_main_o;
    end
  end
endmodule : rcs_far_model

`default_nettype wire

// *** verif/reset_clock_supervisor_test.sv ***
`timescale 1ns/1ns
`default_nettype none

module reset_clock_supervisor_test;
  import rcs_pkg::*;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  rcs_wb_req_s req;
  rcs_wb_rsp_s rsp;
  rcs_pins_s   pins;
  logic        ext_n, wake_pin_n, usb, main_en, wrun, wpsel, irq;
  logic [14:0] wcnt;
  logic        osc_main, osc_rc, mcyc;
  logic        sys_rst, clk_rc, wstop, idle, pd, hold, wirq;
  int          n_mismatch = 0;
  int          total_checks = 0;

  always #50 clk_i = ~clk_i;
  assign pins = {ext_n, wake_pin_n, usb, osc_main, osc_rc};

  rcs_supervisor #(.STAB_CYC(20), .WIN_EDGES(2)) rcs_supervisor_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp), .pins_i(pins),
    .wdt_count_i(wcnt), .wdt_run_i(wrun), .wdt_psel_i(wpsel), .mcyc_i(mcyc),
    .irq_i(irq), .sys_reset_o(sys_rst), .clk_sel_rc_o(clk_rc), .wdt_stop_o(wstop),
    .idle_o(idle), .powerdown_o(pd), .core_hold_o(hold), .wake_irq_o(wirq)
  );

  rcs_far_model rcs_far_model_i (
    .clk_i(clk_i), .main_en_i(main_en), .pd_i(pd),
    .osc_main_o(osc_main), .osc_rc_o(osc_rc), .mcyc_o(mcyc)
  );

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                    output logic [7:0] q);
    int k;
    @(posedge clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: {idx, 2'b00}, sel: 4'h1, dat: {24'h0, d}};
    for (k = 0; k < 20; k++)
    begin
      @(posedge clk_i);
      if (rsp.ack === 1'b1)
        break;
    end
    if (k == 20)
    begin
      chk("ack", 1, 0);
      close_out();
    end
    q = rsp.dat[7:0];
    req <= '0;
  endtask : wb

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, idx, d, q);
  endtask : wr

  task automatic rd(input string nm, input logic [7:0] idx, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, idx, 8'h00, q);
    chk(nm, {24'h0, e}, {24'h0, q});
  endtask : rd

  function automatic logic pick(input int s);
    case (s)
      0: return sys_rst;
      1: return pd;
      2: return hold;
      3: return wirq;
      default: return idle;
    endcase
  endfunction : pick

  // Bounded wait for an output level
  task automatic wt(input int s, input logic v, input int mx, output int n);
    for (n = 0; n < mx; n++)
    begin
      @(posedge clk_i);
      if (pick(s) === v)
        break;
    end
    if (n == mx)
    begin
      chk("timeout", 1, 0);
      close_out();
    end
  endtask : wt

  task close_out;
    if (n_mismatch == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial
  begin
    int n, m, bad, seen;
    req = '0; ext_n = 1'b1; wake_pin_n = 1'b1; usb = 1'b0; main_en = 1'b1;
    wcnt = 15'h0; wrun = 1'b0; wpsel = 1'b0; irq = 1'b0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("sys_reset", 1, sys_rst);
    chk("clk_sel_rc", 1, clk_rc);
    wt(0, 1'b0, 3000, n);
    chk("clk_sel_rc", 0, clk_rc);
    // Registers
    wr(8'h87, 8'h0c);
    rd("pctl", 8'h87, 8'h0c);
    wr(8'h87, 8'h00);
    rd("unmapped", 8'h40, 8'h00);
    wr(8'h88, 8'h90);
    rd("pctlx_nomap", 8'h88, 8'h00);
    wr(8'hb1, 8'h10);
    rd("sysctl", 8'hb1, 8'h10);
    rd("pctlx_dflt", 8'h88, 8'h00);
    wr(8'h88, 8'h90);
    rd("pctlx", 8'h88, 8'h90);
    // Idle entry
    wr(8'h87, 8'h21);
    repeat (3) @(posedge clk_i);
    chk("idle_same", 0, idle);
    wr(8'h87, 8'h01);
    wr(8'h87, 8'h20);
    wt(4, 1'b1, 5, n);
    rd("pctl_start", 8'h87, 8'h00);
    irq <= 1'b1;
    wt(4, 1'b0, 5, n);
    irq <= 1'b0;
    // Watchdog reset, both prescalers
    wr(8'hc0, 8'h00);
    for (int p = 0; p < 2; p++)
    begin
      wpsel <= p[0];
      wrun <= 1'b1;
      wcnt <= 15'h7ffc;
      m = 0; bad = 0; seen = 0;
      for (int k = 0; k < 600; k++)
      begin
        @(posedge clk_i);
        wcnt <= 15'h0;
        if (sys_rst === 1'b1)
        begin
          seen = 1;
          if (mcyc === 1'b1)
            m++;
          if (wstop !== 1'b0)
            bad = 1;
        end
        else if (seen == 1)
          break;
      end
      wrun <= 1'b0;
      chk("wdt_trip", 1, seen);
      chk("wdt_len", p ? 128 : 8, m);
      chk("wdt_stop", 0, bad);
      rd("wdstat", 8'hc0, 8'h04);
    end
    // Oscillator failure and recovery
    main_en <= 1'b0;
    wt(0, 1'b1, 1500, n);
    chk("clk_sel_rc", 1, clk_rc);
    chk("wdt_stop", 1, wstop);
    main_en <= 1'b1;
    wt(0, 1'b0, 3000, n);
    chk("stab", 1, n >= 20);
    chk("clk_sel_rc", 0, clk_rc);
    rd("wdstat_osc", 8'hc0, 8'h0c);
    wr(8'hc0, 8'h00);
    rd("wdstat_clr", 8'hc0, 8'h00);
    wr(8'hc0, 8'h0c);
    rd("wdstat_set", 8'hc0, 8'h0c);
    // Power-down and wake-up, pin then USB
    wr(8'hb1, 8'h10);
    for (int i = 0; i < 2; i++)
    begin
      wr(8'h88, i ? 8'h90 : 8'h80);
      wr(8'h87, 8'h03);
      wr(8'h87, 8'h60);
      wt(1, 1'b1, 5, n);
      chk("idle_pd", 0, idle);
      wake_pin_n <= 1'b0;
      if (i == 1)
      begin
        repeat (20) @(posedge clk_i);
        chk("pd_ws", 1, pd);
        wake_pin_n <= 1'b1;
        usb <= 1'b1;
      end
      wt(2, 1'b1, 20, n);
      chk("pd_exit", 0, pd);
      wake_pin_n <= 1'b1;
      usb <= 1'b0;
      wt(3, 1'b1, 3000, n);
      chk("wake_rst", 0, sys_rst);
    end
    // External reset held across oscillator recovery
    ext_n <= 1'b0;
    main_en <= 1'b0;
    wt(0, 1'b1, 1500, n);
    repeat (500) @(posedge clk_i);
    chk("ext_osc_fail", 1, clk_rc);
    main_en <= 1'b1;
    repeat (1000) @(posedge clk_i);
    chk("ext_osc_ok", 0, clk_rc);
    chk("ext_hold", 1, sys_rst);
    ext_n <= 1'b1;
    wt(0, 1'b0, 3000, n);
    rd("wdstat_ext", 8'hc0, 8'h00);
    close_out();
  end
endmodule : reset_clock_supervisor_test

`default_nettype wire
